// file: bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
   import autoneg_advert_pkg::*;

   // ----------------------------------------------------------------
   // stimulus and observation signals
   // ----------------------------------------------------------------
   logic               clk_i   = 1'b0;
   logic               rst_i   = 1'b1;
   logic               wb_cyc  = 1'b0;
   logic               wb_stb  = 1'b0;
   logic               wb_we   = 1'b0;
   logic [SEL_W-1:0]   wb_sel  = 4'h0;
   logic [ADR_W-1:0]   wb_adr  = 8'h00;
   logic [DAT_W-1:0]   wb_dat  = 32'h0000_0000;
   logic [DAT_W-1:0]   wb_dat_o;
   logic               wb_ack_o;
   logic               wb_err_o;
   logic [ADV_W-1:0]   advert_first_phy_o;
   logic [ADV_W-1:0]   advert_second_phy_o;
   // strap sets, bit5..bit0 = manual, fd_fc, autoneg, speed, duplex, fx
   logic [5:0]         strap0  = 6'h00;
   logic [5:0]         strap1  = 6'h00;
   int                 failures    = 0;
   int                 check_count = 0;

   // strap cases cover both flow-control strap settings, fiber mode and the duplex tables
   localparam logic [5:0] S0 [4] = '{6'h10, 6'h24, 6'h1C, 6'h1F};
   localparam logic [5:0] S1 [4] = '{6'h02, 6'h26, 6'h1F, 6'h10};

   always #4 clk_i = ~clk_i;

   autoneg_advert_register i_autoneg_advert_register (
      .clk_i                                  (clk_i),
      .rst_i                                  (rst_i),
      .wb_cyc_i                               (wb_cyc),
      .wb_stb_i                               (wb_stb),
      .wb_we_i                                (wb_we),
      .wb_sel_i                               (wb_sel),
      .wb_adr_i                               (wb_adr),
      .wb_dat_i                               (wb_dat),
      .wb_dat_o                               (wb_dat_o),
      .wb_ack_o                               (wb_ack_o),
      .wb_err_o                               (wb_err_o),
      .manual_flow_ctrl_cfg_first_phy_i       (strap0[5]),
      .manual_flow_ctrl_cfg_second_phy_i      (strap1[5]),
      .full_duplex_flow_ctrl_cfg_first_phy_i  (strap0[4]),
      .full_duplex_flow_ctrl_cfg_second_phy_i (strap1[4]),
      .autoneg_en_cfg_i                       ({strap1[3], strap0[3]}),
      .speed_sel_cfg_i                        ({strap1[2], strap0[2]}),
      .duplex_sel_cfg_i                       ({strap1[1], strap0[1]}),
      .fiber_mode_i                           ({strap1[0], strap0[0]}),
      .advert_first_phy_o                     (advert_first_phy_o),
      .advert_second_phy_o                    (advert_second_phy_o)
   );

   // ----------------------------------------------------------------
   // expected reset word from one strap set
   // ----------------------------------------------------------------
   function automatic logic [15:0] dflt(input logic [5:0] s);
      logic man, fd, an, sp, dx, fx;
      {man, fd, an, sp, dx, fx} = s;
      return {4'h0, !fx & !man & fd, !fx & !man, 1'b0, 2'b11,
              !fx & (an | (!sp & dx)), !fx & (an | !sp), 5'h01};
   endfunction : dflt

   // ----------------------------------------------------------------
   // verdict, comparison and bus tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      if (failures == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // straps settle through the synchroniser while reset is held
   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset

   // one classic cycle; the slave's answer is taken at the edge that samples it
   task automatic wb_xfer(input logic [7:0] adr, input logic we, input logic [31:0] dat,
                          input logic [3:0] sel, output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= adr;
      wb_dat <= dat;
      wb_sel <= sel;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
      end
      rd = wb_dat_o;
      err = wb_err_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
      if (n == 20) begin
         failures++;
         stop_test();
      end
   endtask : wb_xfer

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel, input logic exp_err);
      logic [31:0] rd;
      logic        err;
      wb_xfer(adr, 1'b1, dat, sel, rd, err);
      check("write response", {31'h0, err}, {31'h0, exp_err});
   endtask : wr

   task automatic rd_chk(input string nm, input logic [7:0] adr, input logic [31:0] exp, input logic exp_err);
      logic [31:0] rd;
      logic        err;
      wb_xfer(adr, 1'b0, 32'h0, 4'hF, rd, err);
      check("read response", {31'h0, err}, {31'h0, exp_err});
      check(nm, rd, exp);
   endtask : rd_chk

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      // strap driven defaults, each case starts with a fresh reset
      for (int i = 0; i < 4; i++) begin
         strap0 <= S0[i];
         strap1 <= S1[i];
         do_reset();
         @(posedge clk_i);
         check("first advert", {16'h0, advert_first_phy_o}, {16'h0, dflt(S0[i])});
         check("second advert", {16'h0, advert_second_phy_o}, {16'h0, dflt(S1[i])});
         rd_chk("adv0 reset", 8'h04, {16'h0, dflt(S0[i])}, 1'b0);
         rd_chk("adv1 reset", 8'h44, {16'h0, dflt(S1[i])}, 1'b0);
         rd_chk("strap view", 8'h08, {26'h0, S0[i]}, 1'b0);
      end
      // all writable bits but bit 12, which software keeps at 0; reserved bits stay 0
      wr(8'h04, 32'hFFFF_EFFF, 4'hF, 1'b0);
      rd_chk("adv0 ones", 8'h04, 32'h0000_ADFF, 1'b0);
      check("first advert ones", {16'h0, advert_first_phy_o}, 32'h0000_ADFF);
      check("second advert kept", {16'h0, advert_second_phy_o}, {16'h0, dflt(S1[3])});
      wr(8'h04, 32'h0000_0000, 4'hF, 1'b0);
      rd_chk("adv0 zeros", 8'h04, 32'h0000_0000, 1'b0);
      // byte lanes apply on their own
      wr(8'h04, 32'h0000_A5C3, 4'h1, 1'b0);
      rd_chk("adv0 low lane", 8'h04, 32'h0000_00C3, 1'b0);
      wr(8'h04, 32'hFFFF_EFFF, 4'h2, 1'b0);
      rd_chk("adv0 high lane", 8'h04, 32'h0000_ADC3, 1'b0);
      // second phy, bit 9 written as 1 must not stick
      wr(8'h44, 32'h0000_0234, 4'h3, 1'b0);
      rd_chk("adv1 write", 8'h44, 32'h0000_0034, 1'b0);
      rd_chk("adv0 kept", 8'h04, 32'h0000_ADC3, 1'b0);
      // strap view ignores writes
      wr(8'h08, 32'h0000_003F, 4'hF, 1'b0);
      rd_chk("strap view kept", 8'h08, {26'h0, S0[3]}, 1'b0);
      // unmapped places answer with an error and change nothing
      wr(8'h0C, 32'hFFFF_FFFF, 4'hF, 1'b1);
      rd_chk("unmapped 0C", 8'h0C, 32'h0000_0000, 1'b1);
      rd_chk("unmapped 00", 8'h00, 32'h0000_0000, 1'b1);
      rd_chk("unmapped 84", 8'h84, 32'h0000_0000, 1'b1);
      rd_chk("adv0 after err", 8'h04, 32'h0000_ADC3, 1'b0);
      stop_test();
   end

endmodule : testbench

`default_nettype wire

// file: rtl/autoneg_advert_pkg.sv
package autoneg_advert_pkg;

   // ----------------------------------------------------------------
   // bus map
   // ----------------------------------------------------------------
   localparam int           NUM_PHY    = 2;
   localparam int           ADR_W      = 8;
   localparam int           DAT_W      = 32;
   localparam int           SEL_W      = 4;
   localparam logic [7:0]   ADV_OFS    = 8'h04;  // advertisement word
   localparam logic [7:0]   STRAP_OFS  = 8'h08;  // synchronised strap view
   localparam int           PHY_LSB    = 6;      // phy index sits above this
   localparam int           OFS_LSB    = 2;      // word aligned offsets

   // ----------------------------------------------------------------
   // advertisement field layout
   // ----------------------------------------------------------------
   localparam int           ADV_W          = 16;
   localparam int           NEXT_PAGE_BIT  = 15;
   localparam int           RSVD_HI_BIT    = 14;
   localparam int           REM_FAULT_BIT  = 13;
   localparam int           EXT_NP_BIT     = 12;
   localparam int           ASYM_PAUSE_BIT = 11;
   localparam int           SYM_PAUSE_BIT  = 10;
   localparam int           RSVD_LO_BIT    = 9;
   localparam int           X100_FD_BIT    = 8;
   localparam int           X100_HD_BIT    = 7;
   localparam int           T10_FD_BIT     = 6;
   localparam int           T10_HD_BIT     = 5;
   localparam int           SELECT_HI      = 4;
   localparam int           SELECT_LO      = 0;

   // reserved bits 14 and 9 are left out of the writable mask
   localparam logic [15:0]  ADV_WR_MASK    = 16'hBDFF;

   // ----------------------------------------------------------------
   // reset values of the fixed fields
   // ----------------------------------------------------------------
   localparam logic         NEXT_PAGE_RST  = 1'b0;
   localparam logic         REM_FAULT_RST  = 1'b0;
   localparam logic         EXT_NP_RST     = 1'b0;
   localparam logic         X100_FD_RST    = 1'b1;
   localparam logic         X100_HD_RST    = 1'b1;
   localparam logic [4:0]   SELECT_802_3   = 5'h01;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic manual_fc;   // manual flow control strap
      logic fd_fc;       // full-duplex flow control strap
      logic autoneg;     // auto-negotiation enable strap
      logic speed;       // speed select strap
      logic duplex;      // duplex select strap
      logic fx_mode;     // 100BASE-FX operation
   } strap_s;

   localparam int           STRAP_W = $bits(strap_s);

   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [SEL_W-1:0]  sel;
      logic [ADR_W-1:0]  adr;
      logic [DAT_W-1:0]  dat;
   } wb_req_s;

endpackage : autoneg_advert_pkg

// file: rtl/autoneg_advert_register.sv
// Behaviour
// - advertisement word sits at offset 4, 16 bits wide, one per internal phy
// - bit 15 next page ability, writable, resets to 0
// - bit 13 remote fault advertise, writable, resets to 0
// - bit 11 writable asymmetric pause advertisement
// - bit 10 writable symmetric pause advertisement
// - bit 8 writable 100BASE-X full duplex, resets to 1
// - bit 7 writable 100BASE-X half duplex, resets to 1
// - bit 6 writable 10BASE-T full duplex advertisement
// - bit 5 writable 10BASE-T half duplex advertisement
// - bits 4:0 writable selector, resets to 00001 for IEEE 802.3
// - manual strap 0: bit 10 resets 1, bit 11 from full-duplex strap
// - manual strap 1: pause bits 10 and 11 reset to 0
// - fiber mode: both pause bits reset to 0 regardless of straps
// - bit 6 resets to autoneg OR (NOT speed AND duplex)
// - bit 5 resets to autoneg OR NOT speed
// - fiber mode: bits 6 and 5 reset to 0
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none

module autoneg_advert_register
   import autoneg_advert_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [SEL_W-1:0]  wb_sel_i,
   input  wire logic [ADR_W-1:0]  wb_adr_i,
   input  wire logic [DAT_W-1:0]  wb_dat_i,
   output logic      [DAT_W-1:0]  wb_dat_o,
   output logic                   wb_ack_o,
   output logic                   wb_err_o,
   input  wire logic              manual_flow_ctrl_cfg_first_phy_i,
   input  wire logic              manual_flow_ctrl_cfg_second_phy_i,
   input  wire logic              full_duplex_flow_ctrl_cfg_first_phy_i,
   input  wire logic              full_duplex_flow_ctrl_cfg_second_phy_i,
   input  wire logic [NUM_PHY-1:0] autoneg_en_cfg_i,
   input  wire logic [NUM_PHY-1:0] speed_sel_cfg_i,
   input  wire logic [NUM_PHY-1:0] duplex_sel_cfg_i,
   input  wire logic [NUM_PHY-1:0] fiber_mode_i,
   output logic      [ADV_W-1:0]  advert_first_phy_o,
   output logic      [ADV_W-1:0]  advert_second_phy_o
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // strap driven reset word; fiber mode overrides every strap term
   function automatic logic [ADV_W-1:0] default_adv(input strap_s s);
      logic [ADV_W-1:0] v;
      v                      = '0;
      v[NEXT_PAGE_BIT]       = NEXT_PAGE_RST;
      v[REM_FAULT_BIT]       = REM_FAULT_RST;
      v[EXT_NP_BIT]          = EXT_NP_RST;
      v[X100_FD_BIT]         = X100_FD_RST;
      v[X100_HD_BIT]         = X100_HD_RST;
      v[SELECT_HI:SELECT_LO] = SELECT_802_3;
      v[SYM_PAUSE_BIT]       = !s.fx_mode && !s.manual_fc;
      v[ASYM_PAUSE_BIT]      = !s.fx_mode && !s.manual_fc && s.fd_fc;
      v[T10_FD_BIT]          = !s.fx_mode && (s.autoneg || (!s.speed && s.duplex));
      v[T10_HD_BIT]          = !s.fx_mode && (s.autoneg || !s.speed);
      return v;
   endfunction : default_adv

   // word address match for one phy slot
   function automatic logic addr_hit(input logic [ADR_W-1:0] adr,
                                     input logic [1:0]       phy,
                                     input logic [7:0]       ofs);
      return (adr[ADR_W-1:PHY_LSB] == phy) &&
             (adr[PHY_LSB-1:OFS_LSB] == ofs[PHY_LSB-1:OFS_LSB]);
   endfunction : addr_hit

   // byte-lane merge; only the low two lanes carry register bits
   function automatic logic [ADV_W-1:0] merge_write(input logic [ADV_W-1:0] old,
                                                    input logic [DAT_W-1:0] dat,
                                                    input logic [SEL_W-1:0] sel);
      logic [ADV_W-1:0] v;
      v = old;
      if (sel[0]) begin
         v[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         v[15:8] = dat[15:8];
      end
      return v & ADV_WR_MASK;
   endfunction : merge_write

   // ----------------------------------------------------------------
   // strap synchronisers
   // ----------------------------------------------------------------
   strap_s      strap_raw  [NUM_PHY];
   strap_s      strap_meta [NUM_PHY];
   strap_s      strap_sync [NUM_PHY];

   // pin order folded into one carrier per phy
   always_comb begin
      strap_raw[0] = '{manual_fc: manual_flow_ctrl_cfg_first_phy_i,
                       fd_fc:     full_duplex_flow_ctrl_cfg_first_phy_i,
                       autoneg:   autoneg_en_cfg_i[0],
                       speed:     speed_sel_cfg_i[0],
                       duplex:    duplex_sel_cfg_i[0],
                       fx_mode:   fiber_mode_i[0]};
      strap_raw[1] = '{manual_fc: manual_flow_ctrl_cfg_second_phy_i,
                       fd_fc:     full_duplex_flow_ctrl_cfg_second_phy_i,
                       autoneg:   autoneg_en_cfg_i[1],
                       speed:     speed_sel_cfg_i[1],
                       duplex:    duplex_sel_cfg_i[1],
                       fx_mode:   fiber_mode_i[1]};
   end

   // two stages; straps are pins, so reset must outlast the pipe
   always_ff @(posedge clk_i) begin
      for (int p = 0; p < NUM_PHY; p++) begin
         strap_meta[p] <= strap_raw[p];
         strap_sync[p] <= strap_meta[p];
      end
   end

   // ----------------------------------------------------------------
   // wishbone decode
   // ----------------------------------------------------------------
   wb_req_s           req;
   logic              new_req;
   logic [NUM_PHY-1:0] adv_hit;
   logic [NUM_PHY-1:0] strap_hit;
   logic              mapped;
   logic [DAT_W-1:0]  rd_word;
   logic [ADV_W-1:0]  adv      [NUM_PHY];   // declared here, the read mux below uses it

   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                  sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

   // a request is served once; the ack cycle itself is not a new request
   assign new_req = req.cyc && req.stb && !wb_ack_o && !wb_err_o;

   // slot match and read multiplexer
   always_comb begin
      rd_word = '0;
      for (int p = 0; p < NUM_PHY; p++) begin
         adv_hit[p]   = addr_hit(req.adr, 2'(p), ADV_OFS);
         strap_hit[p] = addr_hit(req.adr, 2'(p), STRAP_OFS);
         if (adv_hit[p]) begin
            rd_word = DAT_W'(adv[p]);
         end
         if (strap_hit[p]) begin
            rd_word = DAT_W'(strap_sync[p]);
         end
      end
      mapped = |{adv_hit, strap_hit};
   end

   // ----------------------------------------------------------------
   // advertisement registers
   // ----------------------------------------------------------------
   logic [ADV_W-1:0]  next_adv [NUM_PHY];

   // write merge; bit 12 is stored as written, software keeps it at 0
   always_comb begin
      for (int p = 0; p < NUM_PHY; p++) begin
         next_adv[p] = merge_write(adv[p], req.dat, req.sel);
      end
   end

   // reset reloads from the straps, a write lands on the ack edge
   always_ff @(posedge clk_i) begin
      for (int p = 0; p < NUM_PHY; p++) begin
         if (rst_i) begin
            adv[p] <= default_adv(strap_sync[p]);
         end else if (new_req && req.we && adv_hit[p]) begin
            adv[p] <= next_adv[p];
         end
      end
   end

   assign advert_first_phy_o  = adv[0];
   assign advert_second_phy_o = adv[1];

   // ----------------------------------------------------------------
   // bus answer
   // ----------------------------------------------------------------

   // one cycle answer; err for unmapped words keeps software honest
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
      end else begin
         wb_ack_o <= new_req && mapped;
         wb_err_o <= new_req && !mapped;
      end
   end

   // read data registered; writes and unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (new_req) begin
         wb_dat_o <= (req.we || !mapped) ? '0 : rd_word;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_new_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   endsequence

   sequence s_adv_read;
      s_new_req and (!wb_we_i && addr_hit(wb_adr_i, 2'h0, ADV_OFS));
   endsequence

   sequence s_adv_write;
      s_new_req and (wb_we_i && wb_sel_i[1:0] == 2'h3 &&
                     addr_hit(wb_adr_i, 2'h0, ADV_OFS));
   endsequence

   property p_adv_readback;
      @(posedge clk_i) disable iff (rst_i)
      s_adv_read |=> wb_ack_o && wb_dat_o == DAT_W'($past(adv[0]));
   endproperty
   a_adv_readback: assert property (p_adv_readback)
      else $error("advertisement readback mismatch");

   property p_write_flags;
      @(posedge clk_i) disable iff (rst_i)
      s_adv_write |=> (adv[0] == ($past(wb_dat_i[15:0]) & ADV_WR_MASK)) ##1 $stable(adv[0]);
   endproperty
   a_write_flags: assert property (p_write_flags)
      else $error("advertisement write did not land");

   property p_reserved_zero;
      @(posedge clk_i) disable iff (rst_i)
      !adv[0][RSVD_HI_BIT] && !adv[0][RSVD_LO_BIT] && !wb_dat_o[RSVD_HI_BIT];
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved advertisement bit set");

   property p_reset_fixed;
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> adv[0][X100_FD_BIT] && adv[0][X100_HD_BIT] &&
                       !adv[0][NEXT_PAGE_BIT] && !adv[0][REM_FAULT_BIT] &&
                       adv[0][SELECT_HI:SELECT_LO] == SELECT_802_3;
   endproperty
   a_reset_fixed: assert property (p_reset_fixed)
      else $error("fixed reset field wrong");

   property p_pause_auto;
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) && !$past(strap_sync[0].manual_fc) && !$past(strap_sync[0].fx_mode)
      |-> adv[0][SYM_PAUSE_BIT] && adv[0][ASYM_PAUSE_BIT] == $past(strap_sync[0].fd_fc);
   endproperty
   a_pause_auto: assert property (p_pause_auto)
      else $error("pause defaults wrong with manual strap low");

   property p_pause_manual;
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) && ($past(strap_sync[0].manual_fc) || $past(strap_sync[0].fx_mode))
      |-> !adv[0][SYM_PAUSE_BIT] && !adv[0][ASYM_PAUSE_BIT];
   endproperty
   a_pause_manual: assert property (p_pause_manual)
      else $error("pause bits not cleared at reset");

   property p_ten_full;
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) && !$past(strap_sync[0].fx_mode) |->
         adv[0][T10_FD_BIT] == ($past(strap_sync[0].autoneg) ||
                                (!$past(strap_sync[0].speed) && $past(strap_sync[0].duplex)));
   endproperty
   a_ten_full: assert property (p_ten_full)
      else $error("10BASE-T full duplex default wrong");

   property p_ten_half;
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) && !$past(strap_sync[0].fx_mode) |->
         adv[0][T10_HD_BIT] == ($past(strap_sync[0].autoneg) || !$past(strap_sync[0].speed));
   endproperty
   a_ten_half: assert property (p_ten_half)
      else $error("10BASE-T half duplex default wrong");

   property p_fiber_ten;
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) && $past(strap_sync[0].fx_mode) |-> !adv[0][T10_FD_BIT] && !adv[0][T10_HD_BIT];
   endproperty
   a_fiber_ten: assert property (p_fiber_ten)
      else $error("10BASE-T bits set in fiber mode");

   property p_single_answer;
      @(posedge clk_i) disable iff (rst_i)
      s_new_req |=> (wb_ack_o != wb_err_o) ##1 !wb_ack_o && !wb_err_o;
   endproperty
   a_single_answer: assert property (p_single_answer)
      else $error("bus answer not exactly one cycle");

   property p_hold_idle;
      @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) && !$past(wb_cyc_i) |-> $stable(adv[0]);
   endproperty
   a_hold_idle: assert property (p_hold_idle)
      else $error("advertisement changed without a write");

endmodule : autoneg_advert_register

`default_nettype wire
